// ### common/acs_cfg.svh
// Constants for the admin command status unit.
// Assumes inclusion from the package and design files.
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH
`define ACS_STATUS_OFFSET   8'hA8
`define ACS_ACTIVE_BIT      31
`define ACS_RESULT_LSB      8
`define ACS_RESULT_MSB      23
`define ACS_ERR_MSB         7
`define ACS_CMD_DISABLE_WQ  5'h07
`define ACS_CMD_DRAIN_WQ    5'h08
`define ACS_CMD_ABORT_WQ    5'h09
`define ACS_CMD_RESET_WQ    5'h0A
`define ACS_CMD_REQ_INTH    5'h0D
`define ACS_CMD_REQ_PERMH   5'h0F
`define ACS_CMD_REL_PERMH   5'h10
`define ACS_CMD_INV_BITMAP  5'h11
`define ACS_CMD_MAX         5'h11
`define ACS_ERR_OK          8'h00
`define ACS_ERR_UNSUP       8'h01
`define ACS_ERR_BAD_WQ      8'h02
`define ACS_ERR_PLATFORM    8'h03
`define ACS_ERR_RSVD_FIELD  8'h04
`define ACS_ERR_HALTED      8'h05
`define ACS_NUM_WQ          8'h10
`endif

// ### common/acs_pkg.sv
// Types for the admin command status unit.
// Assumes acs_cfg.svh on the include path.
`include "acs_cfg.svh"
package acs_pkg;
  typedef struct packed {
    logic [4:0]  code;
    logic [19:0] operand;
  } acs_cmd_s;
  typedef struct packed {
    logic        valid;
    logic [4:0]  code;
    logic [3:0]  group;
    logic [15:0] mask;
    logic [16:0] size;
    logic [63:0] addr;
  } acs_exec_s;
  typedef enum logic [1:0] {ACS_IDLE, ACS_EXEC, ACS_WAIT} acs_state_e;
endpackage : acs_pkg

// ### design/acs_wq_select.sv
// Expands a grouped work-queue command into a per-queue select vector.
// Assumes queue indices 0..255 and a fixed count of implemented queues.
`timescale 1ns/10ps
`default_nettype none
`include "acs_cfg.svh"
module acs_wq_select
  import acs_pkg::*;
(
  input  wire logic [3:0]   group_num,
  input  wire logic [15:0]  group_mask,
  output logic      [255:0] wq_sel,
  output logic              bad_index
);
  genvar i;
  generate
    for (i = 0; i < 256; i++) begin : g_wq
      // Group number matches queue index bits 7:4
      assign wq_sel[i] = (group_num == 4'(i >> 4)) &&
                         group_mask[i % 16]; // see [R07] [R08]
    end
  endgenerate
  // Any selected queue beyond the implemented count is an invalid index
  assign bad_index = |(wq_sel >> `ACS_NUM_WQ); // see [R17]
endmodule : acs_wq_select
`default_nettype wire

// ### design/acs_admin_cmd.sv
// Admin command decoder with status register for a data mover.
// Assumes an execution agent that acknowledges each dispatched command.
//
// Function
// [R01] Software puts invalidate start address in parameter register, size in operand.
// [R02] Invalidate range is bounded by the size operand from the start address.
// [R03] Capability set: device may cache bitmaps; software invalidates after changes.
// [R04] Capability clear: invalidate command code is reserved.
// [R05] Release handle capability clear: release handle code is reserved.
// [R06] Disable, drain, abort, reset act on up to 16 queues at once.
// [R07] Group number in operand 19:16 matches queue index bits 7:4.
// [R08] Operand 15:0 is a bitmask of queues within the group.
// [R09] With at most 16 queues software uses group zero.
// [R10] Queues in different groups need separate commands.
// [R11] Active bit 31 sets as soon as a command is written.
// [R12] Software ignores result and error while active.
// [R13] Completion clears active and shows outcome; reads 0 before any command.
// [R14] Interrupt handle request returns handle in bits 23:8.
// [R15] Permission handle request returns handle in bits 23:8.
// [R16] Result field unused for all other commands.
// [R17] Error codes 0 success, 1 unsupported, 2 invalid queue index.
// [R18] Error codes 3 platform, 4 reserved field, 5 halted or error.
// [R19] Codes 6 to F unused; 10 to FF command specific.
// [R20] Codes 7 to 10 decode as disable, drain, abort, reset queue.
// [R21] Reserved code completes with unsupported error and no action.
`timescale 1ns/10ps
`default_nettype none
`include "acs_cfg.svh"
module acs_admin_cmd
  import acs_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic         cmd_write,
  input  wire acs_cmd_s     cmd_in,
  input  wire logic [63:0]  command_parameter_register,
  input  wire logic [31:0]  command_capability_mask,
  input  wire logic         device_halted,
  input  wire logic [7:0]   status_addr,
  output logic      [31:0]  status_rdata,
  output logic      [31:0]  admin_command_status,
  output acs_exec_s         exec_req,
  output logic      [255:0] wq_sel,
  output logic      [3:0]   wq_action,
  output logic              exec_busy,
  input  wire logic         exec_done,
  input  wire logic         exec_platform_err,
  input  wire logic [7:0]   exec_err_code,
  input  wire logic [15:0]  exec_handle
);
  acs_state_e  state_reg;
  acs_cmd_s    cmd_reg;
  logic        active_reg;
  logic [15:0] result_reg;
  logic [7:0]  err_reg;
  logic [3:0]  action_reg;
  logic [255:0] sel_next;
  logic        bad_wq;
  logic        is_group;
  logic        supported;
  logic        rsvd_bad;
  logic        returns_handle;
  logic [7:0]  early_err;

  acs_wq_select u_sel (
    .group_num  (cmd_reg.operand[19:16]),
    .group_mask (cmd_reg.operand[15:0]),
    .wq_sel     (sel_next),
    .bad_index  (bad_wq)
  );

  // Grouped queue commands 7..10
  assign is_group = cmd_reg.code >= `ACS_CMD_DISABLE_WQ &&
                    cmd_reg.code <= `ACS_CMD_RESET_WQ; // see [R06] [R20]
  // Capability bits gate command codes; clear bit means reserved
  assign supported = cmd_reg.code != 5'h00 &&
                     cmd_reg.code <= `ACS_CMD_MAX &&
                     command_capability_mask[cmd_reg.code]; // see [R04] [R05]
  assign rsvd_bad =
    (cmd_reg.code == `ACS_CMD_REQ_INTH && cmd_reg.operand[19:17] != 3'h0) ||
    (cmd_reg.code == `ACS_CMD_INV_BITMAP && cmd_reg.operand[19:17] != 3'h0) ||
    ((cmd_reg.code == `ACS_CMD_REQ_PERMH ||
      cmd_reg.code == `ACS_CMD_REL_PERMH) &&
     cmd_reg.operand[19:16] != 4'h0);
  assign returns_handle = cmd_reg.code == `ACS_CMD_REQ_INTH ||
                          cmd_reg.code == `ACS_CMD_REQ_PERMH;

  always_comb begin
    if (device_halted) begin
      early_err = `ACS_ERR_HALTED; // see [R18]
    end else if (!supported) begin
      early_err = `ACS_ERR_UNSUP; // see [R17] [R21]
    end else if (rsvd_bad) begin
      early_err = `ACS_ERR_RSVD_FIELD; // see [R18]
    end else if (is_group && bad_wq) begin
      early_err = `ACS_ERR_BAD_WQ; // see [R17]
    end else begin
      early_err = `ACS_ERR_OK;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cmd_reg <= '0;
    end else if (cmd_write && state_reg == ACS_IDLE) begin
      cmd_reg <= cmd_in;
    end
  end

  // One command at a time; writes while busy are ignored
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ACS_IDLE;
    end else begin
      unique case (state_reg)
        ACS_IDLE: begin
          if (cmd_write) begin
            state_reg <= ACS_EXEC;
          end
        end
        ACS_EXEC: begin
          if (early_err == `ACS_ERR_OK) begin
            state_reg <= ACS_WAIT;
          end else begin
            state_reg <= ACS_IDLE;
          end
        end
        ACS_WAIT: begin
          if (exec_done) begin
            state_reg <= ACS_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      active_reg <= 1'b0; // see [R13]
    end else if (state_reg == ACS_IDLE && cmd_write) begin
      active_reg <= 1'b1; // see [R11]
    end else if ((state_reg == ACS_EXEC && early_err != `ACS_ERR_OK) ||
                 (state_reg == ACS_WAIT && exec_done)) begin
      active_reg <= 1'b0; // see [R13]
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      err_reg    <= `ACS_ERR_OK;
      result_reg <= 16'h0000;
    end else if (state_reg == ACS_EXEC && early_err != `ACS_ERR_OK) begin
      err_reg    <= early_err;
      result_reg <= 16'h0000;
    end else if (state_reg == ACS_WAIT && exec_done) begin
      if (exec_platform_err) begin
        err_reg <= `ACS_ERR_PLATFORM; // see [R18]
      end else begin
        // Agent codes 10..FF pass through; 6..F are not produced
        err_reg <= (exec_err_code >= 8'h10) ? exec_err_code
                                            : `ACS_ERR_OK; // see [R19]
      end
      // Handle only on success; the field is unused after an error
      result_reg <= (returns_handle && !exec_platform_err &&
                     exec_err_code < 8'h10) ?
                    exec_handle : 16'h0000; // see [R14] [R15] [R16]
    end
  end

  // Dispatch pulse and operands; reserved codes never reach the agent
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      exec_req   <= '0;
      wq_sel     <= '0;
      action_reg <= 4'h0;
    end else if (state_reg == ACS_EXEC && early_err == `ACS_ERR_OK) begin
      exec_req.valid <= 1'b1; // see [R21]
      exec_req.code  <= cmd_reg.code;
      exec_req.group <= cmd_reg.operand[19:16];
      exec_req.mask  <= cmd_reg.operand[15:0];
      exec_req.size  <= cmd_reg.operand[16:0]; // see [R02]
      exec_req.addr  <= command_parameter_register; // see [R01] [R02] [R03]
      wq_sel         <= is_group ? sel_next : '0; // see [R06] [R07] [R08]
      // One-hot disable, drain, abort, reset
      action_reg     <= is_group ?
                        4'(4'h1 << (cmd_reg.code - `ACS_CMD_DISABLE_WQ)) :
                        4'h0; // see [R20]
    end else begin
      exec_req.valid <= 1'b0;
    end
  end

  assign wq_action = action_reg;
  assign exec_busy = state_reg == ACS_WAIT;
  assign admin_command_status = {active_reg, 7'h00, result_reg, err_reg};
  assign status_rdata = (status_addr == `ACS_STATUS_OFFSET) ?
                        admin_command_status : 32'h0000_0000;
endmodule : acs_admin_cmd
`default_nettype wire

// ### test/acs_admin_cmd_chk.sv
// Checker for the admin command unit, bound to its top module.
// Assumes one clock domain and the acs_pkg types.
`timescale 1ns/10ps
`default_nettype none
module acs_admin_cmd_chk
  import acs_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        cmd_write,
  input wire acs_cmd_s    cmd_in,
  input wire logic [31:0] command_capability_mask,
  input wire logic        device_halted,
  input wire logic [31:0] admin_command_status,
  input wire acs_exec_s   exec_req,
  input wire logic [3:0]  wq_action,
  input wire logic        exec_busy,
  input wire logic        exec_done,
  input wire logic        exec_platform_err,
  input wire logic [7:0]  exec_err_code,
  input wire logic [15:0] exec_handle
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic       act;
  logic [4:0] code_q;
  assign act = admin_command_status[31];
  // Code of the command in flight, for checks made at completion
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst) code_q <= 5'h00;
    else if (cmd_write && !act) code_q <= cmd_in.code;
  sequence s_take; cmd_write && !act && !device_halted; endsequence
  sequence s_fin; exec_busy && exec_done && !exec_platform_err; endsequence
  property p_set; cmd_write && !act |=> act; endproperty
  a_set: assert property (p_set) else $error("active not set");
  property p_unsup; s_take ##0 !command_capability_mask[cmd_in.code]
    |=> ##1 !act && !exec_req.valid && admin_command_status[7:0] == 8'h01;
  endproperty
  a_unsup: assert property (p_unsup) else $error("reserved code");
  property p_halt; cmd_write && !act && device_halted
    |=> ##1 !act && admin_command_status[7:0] == 8'h05; endproperty
  a_halt: assert property (p_halt) else $error("halted code");
  property p_group; s_take ##0 (cmd_in.code inside {[7:10]} &&
    command_capability_mask[cmd_in.code] && cmd_in.operand[19:16] == 4'h0
    && cmd_in.operand[15:0] != 16'h0000) |=> ##1 exec_req.valid &&
    wq_action == 4'h1 << (code_q - 5'h07); endproperty
  a_group: assert property (p_group) else $error("queue action");
  property p_done; exec_busy && exec_done |=> !act && !exec_busy; endproperty
  a_done: assert property (p_done) else $error("not completed");
  property p_hnd; s_fin ##0 (exec_err_code == 8'h00 && (code_q == 5'h0D ||
    code_q == 5'h0F)) |=> admin_command_status[23:8] == $past(exec_handle)
    && admin_command_status[7:0] == 8'h00; endproperty
  a_hnd: assert property (p_hnd) else $error("handle result");
  property p_nores; s_fin ##0 (code_q != 5'h0D && code_q != 5'h0F)
    |=> admin_command_status[23:8] == 16'h0000; endproperty
  a_nores: assert property (p_nores) else $error("result used");
  property p_plat; exec_busy && exec_done && exec_platform_err
    |=> admin_command_status[7:0] == 8'h03; endproperty
  a_plat: assert property (p_plat) else $error("platform code");
  property p_spec; s_fin ##0 exec_err_code >= 8'h10
    |=> admin_command_status[7:0] == $past(exec_err_code); endproperty
  a_spec: assert property (p_spec) else $error("specific code");
endmodule : acs_admin_cmd_chk
bind acs_admin_cmd acs_admin_cmd_chk u_chk (.clk_sys, .nrst, .cmd_write,
  .cmd_in, .command_capability_mask, .device_halted, .admin_command_status,
  .exec_req, .wq_action, .exec_busy, .exec_done, .exec_platform_err,
  .exec_err_code, .exec_handle);
`default_nettype wire

// ### test/testbench.sv
// Bench for the admin command unit: commands, agent answers, status reads.
// Assumes acs_pkg compiled first; the bench plays the execution agent.
`timescale 1ns/10ps
`default_nettype none
module testbench
  import acs_pkg::*;
;
  logic         clk_sys, nrst, cmd_write, device_halted;
  logic         exec_done, exec_platform_err, exec_busy;
  acs_cmd_s     cmd_in;
  acs_exec_s    exec_req, req_q;
  logic [63:0]  cmd_param;
  logic [31:0]  cap, status_rdata, admin_command_status;
  logic [255:0] wq_sel;
  logic [15:0]  exec_handle;
  logic [7:0]   status_addr, exec_err_code;
  logic [3:0]   wq_action;
  int           err_total = 0, checks_done = 0, cyc = 0;
  acs_admin_cmd dut (.clk_sys, .nrst, .cmd_write, .cmd_in,
    .command_parameter_register(cmd_param), .command_capability_mask(cap),
    .device_halted, .status_addr, .status_rdata, .admin_command_status,
    .exec_req, .wq_sel, .wq_action, .exec_busy, .exec_done,
    .exec_platform_err, .exec_err_code, .exec_handle);
  task automatic chk(input logic [255:0] seen, input logic [255:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    if (err_total == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  // Issue one command, answer as the agent, then read the status back
  task automatic run(input logic [4:0] c, input logic [19:0] op,
                     input logic [7:0] ec, input logic [31:0] exp);
    cmd_in = '{c, op};
    exec_err_code = ec;
    cmd_write = 1'b1;
    @(negedge clk_sys) cmd_write = 1'b0;
    chk(admin_command_status[31], 1'b1);
    // Done changes once per falling edge and is high only while waited for
    for (int i = 0; i < 20 && admin_command_status[31]; i++) begin
      if (exec_req.valid) req_q = exec_req;
      exec_done = exec_busy;
      @(negedge clk_sys);
    end
    exec_done = 1'b0;
    chk(status_rdata, exp);
  endtask : run
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // A run longer than 3000 cycles ends as a failure
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc > 3000) begin
      err_total++;
      tally_and_finish();
    end
  end
  initial begin
    {nrst, cmd_write, device_halted, exec_done, exec_platform_err} = '0;
    {cmd_in, exec_err_code, req_q} = '0;
    cmd_param = 64'h0123_4567_89AB_CDEF;
    cap = 32'hFFFF_FFFF;
    status_addr = 8'hA8;
    exec_handle = 16'hBEEF;
    repeat (4) @(negedge clk_sys);
    nrst = 1'b1;
    chk(status_rdata, 32'h0);
    for (int c = 7; c <= 10; c++) begin
      run(c[4:0], 20'h00092, 8'h00, 32'h0);
      chk(wq_sel, 256'h92);
      chk(wq_action, 4'h1 << (c - 7));
      chk(req_q.group, 4'h0);
      chk(req_q.mask, 16'h0092);
    end
    run(5'h08, 20'h10003, 8'h00, 32'h2);
    run(5'h0D, 20'h00005, 8'h00, 32'h00BE_EF00);
    exec_handle = 16'h1234;
    run(5'h0F, 20'h00007, 8'h00, 32'h0012_3400);
    run(5'h11, 20'h1ABCD, 8'h00, 32'h0);
    chk(req_q.addr, 64'h0123_4567_89AB_CDEF);
    chk(req_q.size, 17'h1ABCD);
    chk(req_q.code, 5'h11);
    run(5'h0D, 20'hE0005, 8'h00, 32'h4);
    run(5'h0F, 20'h00001, 8'h20, 32'h20);
    run(5'h09, 20'h00001, 8'h07, 32'h0);
    exec_platform_err = 1'b1;
    run(5'h07, 20'h00001, 8'h00, 32'h3);
    exec_platform_err = 1'b0;
    cap = 32'hFFFC_FFFF;
    req_q = '0;
    run(5'h11, 20'h00010, 8'h00, 32'h1);
    run(5'h10, 20'h00003, 8'h00, 32'h1);
    chk(req_q.valid, 1'b0);
    device_halted = 1'b1;
    run(5'h07, 20'h00001, 8'h00, 32'h5);
    status_addr = 8'hA4;
    @(negedge clk_sys);
    chk(status_rdata, 32'h0);
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
